// File: shared/masl_defines.svh
`ifndef MASL_DEFINES_SVH
`define MASL_DEFINES_SVH
`define MASL_OFF_CMD 12'h000
`define MASL_OFF_ACC 12'h004
`define MASL_OFF_FLAGS 12'h008
`define MASL_OFF_PC 12'h00C
`define MASL_OFF_MEM 12'h100
`define MASL_MEM_WORDS 88
`define MASL_FLAG_C 0
`define MASL_FLAG_AC 1
`define MASL_FLAG_Z 2
`define MASL_FLAG_OV 3
`define MASL_FLAG_PDF 4
`define MASL_FLAG_TO 5
`define MASL_CMD_OP_LSB 16
`define MASL_CMD_ADDR_LSB 8
`define MASL_BCD_LIMIT 4'h9
`define MASL_BCD_FIX 4'h6
`define MASL_CLK_PERIOD_NS 8
`define MASL_INSTR_SYSCLKS 4
`define MASL_PCL_EXTRA_SYSCLKS 4
`define MASL_PC_RESET 12'h000
`endif

// File: shared/masl_pkg.sv
package masl_pkg;
    typedef enum logic [3:0] {
        MASL_OP_NOP = 4'h0,
        MASL_OP_COMPLEMENT_TO_ACC = 4'h1,
        MASL_OP_DECADJ = 4'h2,
        MASL_OP_DECREMENT_TO_ACC = 4'h3,
        MASL_OP_DEC = 4'h4,
        MASL_OP_INC = 4'h5,
        MASL_OP_INCA = 4'h6,
        MASL_OP_HALT = 4'h7,
        MASL_OP_JMP = 4'h8,
        MASL_OP_MOV_AM = 4'h9,
        MASL_OP_MOV_AX = 4'hA,
        MASL_OP_MOV_MA = 4'hB,
        MASL_OP_OR_AM = 4'hC,
        MASL_OP_OR_AX = 4'hD,
        MASL_OP_ORM = 4'hE
    } masl_op_e;
    typedef struct packed {
        logic to;
        logic power_down_flag;
        logic ov;
        logic z;
        logic ac;
        logic c;
    } masl_flags_s;
    typedef struct packed {
        logic [7:0] value;
        logic [7:0] acc;
        logic cin;
        logic zin;
    } masl_alu_in_s;
    typedef struct packed {
        logic [7:0] result;
        logic to_mem;
        logic z;
        logic c;
        logic set_z;
        logic set_c;
    } masl_alu_out_s;
endpackage

// File: core/masl_alu.sv
`timescale 1ns/1ps
`include "masl_defines.svh"
module masl_alu
(
    input wire masl_pkg::masl_op_e op,
    input wire masl_pkg::masl_alu_in_s din,
    output masl_pkg::masl_alu_out_s dout
);
    logic [4:0] lo_sum;
    logic [4:0] hi_sum;
    logic nib_carry;
    always_comb
    begin
        dout = '0;
        nib_carry = 1'b0;
        lo_sum = 5'h00;
        hi_sum = 5'h00;
        unique case (op)
            masl_pkg::MASL_OP_COMPLEMENT_TO_ACC:
            begin
                dout.result = ~din.value;
                dout.set_z = 1'b1;
            end
            masl_pkg::MASL_OP_DECADJ:
            begin
                // Low nibble
                if (din.acc[3:0] > `MASL_BCD_LIMIT || din.cin)
                begin
                    lo_sum = {1'b0, din.acc[3:0]} + {1'b0, `MASL_BCD_FIX};
                end
                else
                begin
                    lo_sum = {1'b0, din.acc[3:0]};
                end
                nib_carry = din.acc[3:0] > `MASL_BCD_LIMIT;
                // High nine plus nibble carry also exceeds nine
                if (din.acc[7:4] > `MASL_BCD_LIMIT || din.cin
                    || (nib_carry && din.acc[7:4] == `MASL_BCD_LIMIT))
                begin
                    hi_sum = {1'b0, din.acc[7:4]} + {1'b0, `MASL_BCD_FIX}
                        + {4'h0, nib_carry};
                end
                else
                begin
                    hi_sum = {1'b0, din.acc[7:4]} + {4'h0, nib_carry};
                end
                dout.result = {hi_sum[3:0], lo_sum[3:0]};
                dout.to_mem = 1'b1;
                dout.c = hi_sum[4] | din.cin;
                dout.set_c = 1'b1;
            end
            masl_pkg::MASL_OP_DECREMENT_TO_ACC:
            begin
                dout.result = din.value - 8'h01;
                dout.set_z = 1'b1;
            end
            masl_pkg::MASL_OP_DEC:
            begin
                dout.result = din.value - 8'h01;
                dout.to_mem = 1'b1;
                dout.set_z = 1'b1;
            end
            masl_pkg::MASL_OP_INC:
            begin
                dout.result = din.value + 8'h01;
                dout.to_mem = 1'b1;
                dout.set_z = 1'b1;
            end
            masl_pkg::MASL_OP_INCA:
            begin
                dout.result = din.value + 8'h01;
                dout.set_z = 1'b1;
            end
            masl_pkg::MASL_OP_MOV_AM,
            masl_pkg::MASL_OP_MOV_AX:
            begin
                dout.result = din.value;
            end
            masl_pkg::MASL_OP_MOV_MA:
            begin
                dout.result = din.acc;
                dout.to_mem = 1'b1;
            end
            masl_pkg::MASL_OP_OR_AM,
            masl_pkg::MASL_OP_OR_AX:
            begin
                dout.result = din.acc | din.value;
                dout.set_z = 1'b1;
            end
            masl_pkg::MASL_OP_ORM:
            begin
                dout.result = din.acc | din.value;
                dout.to_mem = 1'b1;
                dout.set_z = 1'b1;
            end
            default:
            begin
                dout.result = din.acc;
            end
        endcase
        dout.z = (dout.result == 8'h00);
    end
endmodule // masl_alu

// File: core/masl_core.sv
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "masl_defines.svh"
// What this block does
// - Complement memory byte into accumulator; memory unchanged; only zero flag updated.
// - Decimal adjust converts accumulator to packed BCD, nibble by nibble.
// - Low nibble above nine makes an internal carry feeding the high nibble.
// - Nibble above nine or with carry gets plus six, else passes.
// - Decimal adjust result goes to memory; only carry flag changes.
// - Decrement memory byte into accumulator; memory kept; only zero flag.
// - Store accumulator to memory without touching any flag.
// - OR accumulator with memory into accumulator, updating only zero flag.
// - Writing the low program counter adds one instruction cycle, four clocks.
module masl_core
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic sys_clock_stop,
    output logic watchdog_clear
);
    typedef enum logic [1:0] {
        MASL_ST_IDLE = 2'b00,
        MASL_ST_EXEC = 2'b01,
        MASL_ST_DONE = 2'b10
    } masl_state_e;
    logic [7:0] mem_r [0:`MASL_MEM_WORDS-1];
    logic [7:0] mem_nxt [0:`MASL_MEM_WORDS-1];
    logic [7:0] acc_r, acc_nxt;
    logic [11:0] pc_r, pc_nxt;
    masl_pkg::masl_flags_s flags_r, flags_nxt;
    masl_state_e state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    masl_pkg::masl_op_e op_r, op_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [7:0] imm_r, imm_nxt;
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt, stop_nxt, wdc_nxt;
    logic stop_r, wdc_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    masl_pkg::masl_alu_in_s alu_in;
    masl_pkg::masl_alu_out_s alu_out;
    logic acc_xfer, mem_hit, addr_ok;
    logic [6:0] mem_idx;
    masl_alu u_alu
    (
        .op(op_r),
        .din(alu_in),
        .dout(alu_out)
    );
    assign addr_ok = addr_r < 8'(`MASL_MEM_WORDS);
    always_comb
    begin
        alu_in.acc = acc_r;
        alu_in.cin = flags_r.c;
        alu_in.zin = flags_r.z;
        if (op_r == masl_pkg::MASL_OP_MOV_AX || op_r == masl_pkg::MASL_OP_OR_AX)
        begin
            alu_in.value = imm_r;
        end
        else
        begin
            alu_in.value = addr_ok ? mem_r[addr_r[6:0]] : 8'h00;
        end
    end
    assign acc_xfer = psel && penable && !pready_r;
    assign mem_hit = paddr >= `MASL_OFF_MEM
        && paddr < (`MASL_OFF_MEM + 12'(4 * `MASL_MEM_WORDS));
    assign mem_idx = 7'((paddr - `MASL_OFF_MEM) >> 2);
    always_comb
    begin
        for (int i = 0; i < `MASL_MEM_WORDS; i++)
        begin
            mem_nxt[i] = mem_r[i];
        end
        acc_nxt = acc_r;
        pc_nxt = pc_r;
        flags_nxt = flags_r;
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        imm_nxt = imm_r;
        prdata_nxt = 32'h0000_0000;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        stop_nxt = stop_r;
        wdc_nxt = 1'b0;
        unique case (state_r)
            MASL_ST_IDLE:
            begin
                if (acc_xfer)
                begin
                    pready_nxt = 1'b1;
                    if (pwrite)
                    begin
                        if (paddr == `MASL_OFF_CMD)
                        begin
                            op_nxt = masl_pkg::masl_op_e'(pwdata[`MASL_CMD_OP_LSB +: 4]);
                            addr_nxt = pwdata[`MASL_CMD_ADDR_LSB +: 8];
                            imm_nxt = pwdata[7:0];
                            cnt_nxt = 4'(`MASL_INSTR_SYSCLKS - 1);
                            state_nxt = MASL_ST_EXEC;
                            stop_nxt = 1'b0;
                        end
                        else if (paddr == `MASL_OFF_ACC)
                        begin
                            acc_nxt = pwdata[7:0];
                        end
                        else if (paddr == `MASL_OFF_FLAGS)
                        begin
                            flags_nxt = pwdata[5:0];
                        end
                        else if (paddr == `MASL_OFF_PC)
                        begin
                            pc_nxt = pwdata[11:0];
                        end
                        else if (mem_hit)
                        begin
                            mem_nxt[mem_idx] = pwdata[7:0];
                        end
                        else
                        begin
                            pslverr_nxt = 1'b1;
                        end
                    end
                    else
                    begin
                        if (paddr == `MASL_OFF_CMD)
                        begin
                            prdata_nxt = {31'h0, stop_r};
                        end
                        else if (paddr == `MASL_OFF_ACC)
                        begin
                            prdata_nxt = {24'h0, acc_r};
                        end
                        else if (paddr == `MASL_OFF_FLAGS)
                        begin
                            prdata_nxt = {26'h0, flags_r};
                        end
                        else if (paddr == `MASL_OFF_PC)
                        begin
                            prdata_nxt = {20'h0, pc_r};
                        end
                        else if (mem_hit)
                        begin
                            prdata_nxt = {24'h0, mem_r[mem_idx]};
                        end
                        else
                        begin
                            pslverr_nxt = 1'b1;
                        end
                    end
                end
            end
            MASL_ST_EXEC:
            begin
                // Instruction takes effect at end of its cycle
                if (cnt_r != 4'h0)
                begin
                    cnt_nxt = cnt_r - 4'h1;
                end
                else
                begin
                    state_nxt = MASL_ST_IDLE;
                    pc_nxt = pc_r + 12'h001;
                    if (op_r == masl_pkg::MASL_OP_JMP)
                    begin
                        pc_nxt = {imm_r[3:0], addr_r};
                        cnt_nxt = 4'(`MASL_PCL_EXTRA_SYSCLKS - 1);
                        state_nxt = MASL_ST_DONE;
                    end
                    else if (op_r == masl_pkg::MASL_OP_HALT)
                    begin
                        stop_nxt = 1'b1;
                        wdc_nxt = 1'b1;
                        flags_nxt.power_down_flag = 1'b1;
                        flags_nxt.to = 1'b0;
                    end
                    else if (op_r != masl_pkg::MASL_OP_NOP)
                    begin
                        if (alu_out.to_mem)
                        begin
                            if (addr_ok)
                            begin
                                mem_nxt[addr_r[6:0]] = alu_out.result;
                            end
                        end
                        else
                        begin
                            acc_nxt = alu_out.result;
                        end
                        if (alu_out.set_z)
                        begin
                            flags_nxt.z = alu_out.z;
                        end
                        if (alu_out.set_c)
                        begin
                            flags_nxt.c = alu_out.c;
                        end
                    end
                end
            end
            MASL_ST_DONE:
            begin
                if (cnt_r != 4'h0)
                begin
                    cnt_nxt = cnt_r - 4'h1;
                end
                else
                begin
                    state_nxt = MASL_ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = MASL_ST_IDLE;
            end
        endcase
        if (state_r != MASL_ST_IDLE && acc_xfer)
        begin
            pready_nxt = 1'b1;
            pslverr_nxt = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < `MASL_MEM_WORDS; i++)
            begin
                mem_r[i] <= 8'h00;
            end
            acc_r <= 8'h00;
            pc_r <= `MASL_PC_RESET;
            flags_r <= '0;
            state_r <= MASL_ST_IDLE;
            cnt_r <= 4'h0;
            op_r <= masl_pkg::MASL_OP_NOP;
            addr_r <= 8'h00;
            imm_r <= 8'h00;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            stop_r <= 1'b0;
            wdc_r <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < `MASL_MEM_WORDS; i++)
            begin
                mem_r[i] <= mem_nxt[i];
            end
            acc_r <= acc_nxt;
            pc_r <= pc_nxt;
            flags_r <= flags_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            imm_r <= imm_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            stop_r <= stop_nxt;
            wdc_r <= wdc_nxt;
        end
    end
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sys_clock_stop = stop_r;
    assign watchdog_clear = wdc_r;
endmodule // masl_core

// File: verification/masl_core_properties.sv
`timescale 1ns/1ps
`include "masl_defines.svh"
module masl_core_properties
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sys_clock_stop,
    input wire logic watchdog_clear
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_cmd_ok;
        psel && penable && pready && !pslverr && pwrite && paddr == `MASL_OFF_CMD;
    endsequence
    sequence s_halt;
        s_cmd_ok ##0 pwdata[19:16] == masl_pkg::MASL_OP_HALT;
    endsequence
    sequence s_jmp;
        s_cmd_ok ##0 pwdata[19:16] == masl_pkg::MASL_OP_JMP;
    endsequence

    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (psel && pready && paddr == 12'h010 |-> pslverr)
        else $error("unmapped access not refused");
    halt_stop_a: assert property (s_halt |-> ##[1:8] sys_clock_stop)
        else $error("halt did not stop clock");
    halt_wdog_a: assert property (s_halt |-> ##[1:8] watchdog_clear)
        else $error("halt did not clear watchdog");
    wdog_pulse_a: assert property (watchdog_clear |=> !watchdog_clear)
        else $error("watchdog clear not a pulse");
    stop_hold_a: assert property (sys_clock_stop && !psel |=> sys_clock_stop)
        else $error("clock stop dropped without command");
    jmp_busy_a: assert property (s_jmp |=> (!(pready && !pslverr))[*5])
        else $error("access accepted during jump cycle");
endmodule // masl_core_properties

bind masl_core masl_core_properties u_masl_core_properties (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_clock_stop(sys_clock_stop),
    .watchdog_clear(watchdog_clear));

// File: verification/masl_core_tb.sv
`timescale 1ns/1ps
`include "masl_defines.svh"
module masl_core_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sys_clock_stop;
    logic watchdog_clear;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int comparisons = 0;
    int n_wdog = 0;
    logic [7:0] din [3] = '{8'h09, 8'h0A, 8'h9A};
    logic [7:0] dout [3] = '{8'h09, 8'h10, 8'h00};

    always #4 pclk = ~pclk;
    always @(posedge pclk)
        if (watchdog_clear === 1'b1)
            n_wdog <= n_wdog + 1;

    masl_core u_masl_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sys_clock_stop(sys_clock_stop), .watchdog_clear(watchdog_clear));

    task report_and_stop;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            n_fail++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask

    task exec(input masl_pkg::masl_op_e op, input logic [7:0] m, input logic [7:0] x);
        apb(1'b1, `MASL_OFF_CMD, {12'h000, op, m, x});
        chk("cmd_err", 32'h0, {31'h0, err});
        repeat (op == masl_pkg::MASL_OP_JMP ? 8 : 4) @(posedge pclk);
    endtask

    function logic [11:0] ma(input int i);
        return `MASL_OFF_MEM + 12'(4 * i);
    endfunction

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("acc_rst", `MASL_OFF_ACC, 32'h0);
        rdchk("flags_rst", `MASL_OFF_FLAGS, 32'h0);
        rdchk("pc_rst", `MASL_OFF_PC, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        $display("Test reset done");
        exec(masl_pkg::MASL_OP_MOV_AX, 8'h00, 8'h5A);
        exec(masl_pkg::MASL_OP_MOV_MA, 8'h03, 8'h00);
        rdchk("mov_mem", ma(3), 32'h5A);
        rdchk("mov_flags", `MASL_OFF_FLAGS, 32'h0);
        apb(1'b1, ma(1), 32'hFF);
        exec(masl_pkg::MASL_OP_COMPLEMENT_TO_ACC, 8'h01, 8'h00);
        rdchk("cpl_acc", `MASL_OFF_ACC, 32'h0);
        rdchk("cpl_mem", ma(1), 32'hFF);
        rdchk("cpl_flags", `MASL_OFF_FLAGS, 32'h04);
        exec(masl_pkg::MASL_OP_COMPLEMENT_TO_ACC, 8'h03, 8'h00);
        rdchk("cpl_acc2", `MASL_OFF_ACC, 32'hA5);
        rdchk("cpl_flags2", `MASL_OFF_FLAGS, 32'h0);
        $display("Test move and complement done");
        exec(masl_pkg::MASL_OP_DECREMENT_TO_ACC, 8'h03, 8'h00);
        rdchk("dec_acc", `MASL_OFF_ACC, 32'h59);
        rdchk("dec_mem", ma(3), 32'h5A);
        apb(1'b1, ma(4), 32'h01);
        exec(masl_pkg::MASL_OP_DECREMENT_TO_ACC, 8'h04, 8'h00);
        rdchk("dec_acc0", `MASL_OFF_ACC, 32'h0);
        rdchk("dec_flags", `MASL_OFF_FLAGS, 32'h04);
        exec(masl_pkg::MASL_OP_OR_AM, 8'h03, 8'h00);
        rdchk("or_acc", `MASL_OFF_ACC, 32'h5A);
        rdchk("or_flags", `MASL_OFF_FLAGS, 32'h0);
        exec(masl_pkg::MASL_OP_OR_AX, 8'h00, 8'h81);
        rdchk("orx_acc", `MASL_OFF_ACC, 32'hDB);
        $display("Test decrement and or done");
        exec(masl_pkg::MASL_OP_INC, 8'h01, 8'h00);
        rdchk("inc_mem", ma(1), 32'h0);
        rdchk("inc_flags", `MASL_OFF_FLAGS, 32'h04);
        exec(masl_pkg::MASL_OP_DEC, 8'h01, 8'h00);
        rdchk("decm_mem", ma(1), 32'hFF);
        exec(masl_pkg::MASL_OP_INCA, 8'h03, 8'h00);
        rdchk("inca_acc", `MASL_OFF_ACC, 32'h5B);
        exec(masl_pkg::MASL_OP_ORM, 8'h04, 8'h00);
        rdchk("orm_mem", ma(4), 32'h5B);
        rdchk("orm_acc", `MASL_OFF_ACC, 32'h5B);
        exec(masl_pkg::MASL_OP_MOV_AM, 8'h01, 8'h00);
        rdchk("mova_acc", `MASL_OFF_ACC, 32'hFF);
        rdchk("mova_flags", `MASL_OFF_FLAGS, 32'h0);
        $display("Test memory forms done");
        for (int i = 0; i < 3; i++)
        begin
            exec(masl_pkg::MASL_OP_MOV_AX, 8'h00, din[i]);
            exec(masl_pkg::MASL_OP_DECADJ, 8'h06, 8'h00);
            rdchk("daa_mem", ma(6), {24'h0, dout[i]});
            rdchk("daa_acc", `MASL_OFF_ACC, {24'h0, din[i]});
            rdchk("daa_flags", `MASL_OFF_FLAGS, (i == 2) ? 32'h01 : 32'h0);
        end
        $display("Test decimal adjust done");
        apb(1'b1, `MASL_OFF_CMD, {12'h000, masl_pkg::MASL_OP_JMP, 8'h34, 8'h02});
        repeat (4) @(posedge pclk);
        apb(1'b0, `MASL_OFF_PC, 32'h0);
        chk("jmp_busy", 32'h1, {31'h0, err});
        repeat (8) @(posedge pclk);
        rdchk("jmp_pc", `MASL_OFF_PC, 32'h234);
        $display("Test jump done");
        exec(masl_pkg::MASL_OP_HALT, 8'h00, 8'h00);
        chk("halt_stop", 32'h1, {31'h0, sys_clock_stop});
        rdchk("halt_pc", `MASL_OFF_PC, 32'h235);
        chk("halt_wdog", 32'h1, 32'(n_wdog));
        rdchk("halt_flags", `MASL_OFF_FLAGS, 32'h11);
        rdchk("halt_cmd", `MASL_OFF_CMD, 32'h1);
        rdchk("halt_mem", ma(3), 32'h5A);
        exec(masl_pkg::MASL_OP_NOP, 8'h00, 8'h00);
        chk("nop_run", 32'h0, {31'h0, sys_clock_stop});
        rdchk("nop_pc", `MASL_OFF_PC, 32'h236);
        $display("Test halt done");
        report_and_stop();
    end
endmodule // masl_core_tb
